// *** rtl/seecp_pkg.sv ***
// constants, opcodes and carrier types for the serial eeprom command port
package seecp_pkg;

   // -----------------------------------------------------------------
   // opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_SET_WEL = 8'h06;
   localparam logic [7:0] OP_CLR_WEL = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;

   // -----------------------------------------------------------------
   // array geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int PAGE_W = 5;
   localparam int ARRAY_BYTES = 8192;
   localparam int PAGE_BYTES = 32;
   localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 13'h1800;
   localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 13'h1000;

   // -----------------------------------------------------------------
   // status byte layout and reset values
   // -----------------------------------------------------------------
   localparam int ST_PPE = 7;
   localparam int ST_BPH = 3;
   localparam int ST_BPL = 2;
   localparam int ST_WEL = 1;
   localparam int ST_BUSY = 0;
   localparam logic [2:0] ST_DONT_CARE = 3'h0;
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QTR = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_RESET = 2'h0;
   localparam logic PPE_RESET = 1'b0;

   // -----------------------------------------------------------------
   // serial framing
   // -----------------------------------------------------------------
   localparam logic [1:0] BY_OPC = 2'h0;
   localparam logic [1:0] BY_AHI = 2'h1;
   localparam logic [1:0] BY_ALO = 2'h2;
   localparam logic [1:0] BY_DATA = 2'h3;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_WC_NS = 5000000;
   localparam int WC_CYCLES = T_WC_NS / CLK_PERIOD_NS;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] op;
      logic [1:0] bytes;
      logic [2:0] bitpos;
      logic data_seen;
      logic [7:0] sdata;
   } seecp_frame_s;

   typedef enum logic [2:0] {
      WS_IDLE = 3'b001,
      WS_PROG = 3'b010,
      WS_WAIT = 3'b100
   } seecp_wstate_e;

endpackage : seecp_pkg

// *** rtl/seecp_top.sv ***
// device-side command logic of the serial eeprom behind its four-wire link
// Function
// R1: data bits are captured from the serial input on each rising serial clock.
// R2: serial output changes only after a falling serial clock edge.
// R3: pause begins with clock low, else at the next falling clock edge; the logic pauses at once at any clock level.
// R4: while paused clocks are ignored, state kept, serial output floated.
// R5: pause ends only when pause_n is raised while the clock is low; the logic resumes whenever pause_n rises.
// R6: host keeps select low during pause and pause_n high when unused.
// R7: every transfer opens with an 8-bit opcode; all fields move msb first.
// R8: opcode 03h is array read, 02h array write, both from following address.
// R9: opcode 06h sets the write enable latch, 04h clears it.
// R10: opcode 01h writes status; successful writes leave the latch cleared.
// R11: a 16-bit address follows read or write; top three bits ignored.
// R12: reads stream bytes with auto-increment, wrap 1FFFh to 0, end on select.
// R13: latch sets only if select rises right after the eight opcode bits.
// R14: page write takes up to 32 bytes, wrapping inside the page.
// R15: internal write starts only if select rises right after a whole byte.
// R16: array reads are refused while an internal write is running.
// R17: latch cleared when an internal write completes and at reset.
// R18: no array or status write completes unless the latch is set.
// R19: status read works at any time, also during an internal write.
// R20: status byte is ppe, three don't-care, bp hi, bp lo, latch, busy.
// R21: write_busy is 1 during an internal write and never written by software.
// R22: latch bit is read-only and always follows set and clear opcodes.
// R23: block-protect bits change only through a status write; the logic also clears them at reset.
// R24: block-protect 01, 10, 11 guard top quarter, top half, whole array.
// R25: protect pin low with ppe set refuses status writes only.
// R26: after reset, a falling select is needed before any sequence acts.
// R27: select rise after a valid write starts the cycle; it cannot be broken.
// R28: the write cycle length is a configurable counter holding busy high.
`timescale 1ns/1ps
`default_nettype none

module seecp_top
   import seecp_pkg::*;
#(
   parameter int WRITE_CYCLES = WC_CYCLES
) (
   // system
   input wire logic i_clk,
   input wire logic i_rst,
   // serial link
   input wire logic i_sck,
   input wire logic i_select_n,
   input wire logic i_sdi,
   output logic o_sdo,
   output logic o_sdo_oe,
   // pins
   input wire logic i_pause_n,
   input wire logic i_protect_pin_n
);

   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);
   localparam logic [PAGE_W-1:0] IDX_LAST = PAGE_W'(PAGE_BYTES - 1);

   // -----------------------------------------------------------------
   // storage and status
   // -----------------------------------------------------------------
   logic [7:0] mem_q [0:ARRAY_BYTES-1];
   logic [7:0] pbuf_q [0:PAGE_BYTES-1];
   logic [PAGE_BYTES-1:0] mask_q;
   logic wel_q;
   logic ppe_q;
   logic [1:0] bprot_q;
   seecp_wstate_e ws_q;
   wire busy_w = (ws_q != WS_IDLE);  // see R21

   // -----------------------------------------------------------------
   // link domain: rising edge capture
   // -----------------------------------------------------------------
   seecp_frame_s frm_q;
   logic idle_q;
   // starts known so the system side can compare it before the first frame
   logic frame_tog_q = 1'b0;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic [4:0] ahi_q;
   logic [7:0] pg_q;
   logic [PAGE_W-1:0] col_q;
   logic [ADDR_W-1:0] ptr_q;
   logic rd_ok_q;
   logic rd_act_q;
   logic bsy_s1_q;
   logic bsy_s2_q;

   // pause acts at once at any clock level and ends as soon as pause_n rises
   wire hold_w = !i_pause_n;  // see R3 R4 R5
   wire [2:0] bp_w = idle_q ? BIT_FIRST : frm_q.bitpos;
   wire [1:0] by_w = idle_q ? BY_OPC : frm_q.bytes;
   wire [7:0] byte_w = {sh_q[6:0], i_sdi};  // see R7
   wire done_w = (bp_w == BIT_LAST);
   wire [7:0] op_w = (by_w == BY_OPC) ? byte_w : frm_q.op;
   wire is_read_w = (op_w == OP_READ);
   wire is_write_w = (op_w == OP_WRITE);
   wire is_srd_w = (op_w == OP_STAT_RD);
   wire is_swr_w = (op_w == OP_STAT_WR);
   wire [ADDR_W-1:0] addr_w = {ahi_q, byte_w};  // see R11
   wire [7:0] stat_w = {ppe_q, ST_DONT_CARE, bprot_q, wel_q, bsy_s2_q};  // see R20

   // a frame opens with the first unpaused rising edge after select falls
   always_ff @(posedge i_sck or posedge i_select_n) begin
      if (i_select_n) begin
         idle_q <= 1'b1;
      end else if (!hold_w) begin
         idle_q <= 1'b0;
      end
   end

   // busy only ever read here through two link-clock flops
   always_ff @(posedge i_sck) begin
      bsy_s1_q <= busy_w;
      bsy_s2_q <= bsy_s1_q;
   end

   always_ff @(posedge i_sck) begin
      if (!hold_w) begin  // see R4
         sh_q <= byte_w;  // see R1
         frm_q.bitpos <= bp_w + 3'h1;
         if (idle_q) begin
            frm_q.bytes <= BY_OPC;
            frm_q.data_seen <= 1'b0;
            mask_q <= '0;
            rd_act_q <= 1'b0;
            frame_tog_q <= ~frame_tog_q;
         end
         if (done_w) begin
            if (by_w != BY_DATA) begin
               frm_q.bytes <= by_w + 2'h1;
            end
            case (by_w)
               BY_OPC: begin
                  frm_q.op <= byte_w;  // see R7
                  rd_ok_q <= !bsy_s2_q;  // see R16
                  if (is_srd_w) begin
                     tx_q <= stat_w;  // see R19
                     rd_act_q <= 1'b1;
                  end
               end
               BY_AHI: begin
                  ahi_q <= byte_w[4:0];  // see R11
               end
               BY_ALO: begin
                  ptr_q <= addr_w + 13'h1;
                  col_q <= byte_w[PAGE_W-1:0];
                  pg_q <= addr_w[ADDR_W-1:PAGE_W];
                  if (is_read_w && rd_ok_q) begin
                     tx_q <= mem_q[addr_w];  // see R8
                     rd_act_q <= 1'b1;
                  end
               end
               default: begin
                  if (is_read_w && rd_ok_q) begin
                     tx_q <= mem_q[ptr_q];
                     ptr_q <= ptr_q + 13'h1;  // see R12
                  end
                  if (is_write_w) begin
                     pbuf_q[col_q] <= byte_w;
                     mask_q[col_q] <= 1'b1;
                     col_q <= col_q + 5'h1;  // see R14
                     frm_q.data_seen <= 1'b1;
                  end
               end
            endcase
            if (is_srd_w && by_w != BY_OPC) begin
               tx_q <= stat_w;
            end
            if (is_swr_w && by_w != BY_OPC) begin
               frm_q.sdata <= byte_w;
               frm_q.data_seen <= 1'b1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // link domain: falling edge output and pause
   // -----------------------------------------------------------------
   logic sdo_q;
   logic drv_q;

   always_ff @(negedge i_sck or posedge i_select_n) begin
      if (i_select_n) begin
         sdo_q <= 1'b0;
         drv_q <= 1'b0;
      end else if (i_pause_n) begin  // see R3 R5
         sdo_q <= tx_q[BIT_LAST - frm_q.bitpos];  // see R2
         drv_q <= rd_act_q && !idle_q;
      end
   end

   assign o_sdo = sdo_q;
   assign o_sdo_oe = !i_select_n && i_pause_n && drv_q;  // see R4

   // -----------------------------------------------------------------
   // system domain: pin synchronisers and frame end detection
   // -----------------------------------------------------------------
   logic sel_s1_q;
   logic sel_s2_q;
   logic sel_s3_q;
   logic wp_s1_q;
   logic wp_s2_q;
   logic tog_s1_q;
   logic tog_s2_q;
   logic tog_seen_q;
   logic seen_hi_q;
   logic armed_q;

   always_ff @(posedge i_clk) begin
      sel_s1_q <= i_select_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      wp_s1_q <= i_protect_pin_n;
      wp_s2_q <= wp_s1_q;
      tog_s1_q <= frame_tog_q;
      tog_s2_q <= tog_s1_q;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         seen_hi_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         seen_hi_q <= seen_hi_q || sel_s2_q;
         armed_q <= armed_q || (seen_hi_q && !sel_s2_q);  // see R26
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tog_seen_q <= 1'b0;
      end else if (sel_s2_q && !sel_s3_q) begin
         tog_seen_q <= tog_s2_q;
      end
   end

   // frame fields are steady here: no serial clock runs while deselected
   wire frame_end_w = sel_s2_q && !sel_s3_q && armed_q && (tog_s2_q != tog_seen_q);
   wire exact8_w = (frm_q.bytes == BY_AHI) && (frm_q.bitpos == BIT_FIRST);
   wire whole_w = frm_q.data_seen && (frm_q.bitpos == BIT_FIRST);
   wire set_ok_w = frame_end_w && (frm_q.op == OP_SET_WEL) && exact8_w;  // see R13
   wire clr_ok_w = frame_end_w && (frm_q.op == OP_CLR_WEL) && exact8_w;
   wire wr_ok_w = frame_end_w && (frm_q.op == OP_WRITE) && whole_w;  // see R15
   wire sw_ok_w = frame_end_w && (frm_q.op == OP_STAT_WR) && whole_w;
   wire stat_lock_w = ppe_q && !wp_s2_q;  // see R25
   wire start_wr_w = wr_ok_w && wel_q && !busy_w;  // see R18
   wire start_sw_w = sw_ok_w && wel_q && !busy_w && !stat_lock_w;

   // -----------------------------------------------------------------
   // system domain: self-timed write cycle
   // -----------------------------------------------------------------
   logic [PAGE_W-1:0] idx_q;
   logic [CNT_W-1:0] wc_cnt_q;

   wire [ADDR_W-1:0] prog_addr_w = {pg_q, idx_q};
   wire prot_hit_w = (bprot_q == BP_NONE) ? 1'b0 :
                     (bprot_q == BP_QTR) ? (prog_addr_w >= PROT_QTR_BASE) :
                     (bprot_q == BP_HALF) ? (prog_addr_w >= PROT_HALF_BASE) : 1'b1;  // see R24
   wire prog_we_w = (ws_q == WS_PROG) && mask_q[idx_q] && !prot_hit_w;
   wire wc_done_w = (ws_q == WS_WAIT) && (wc_cnt_q == CNT_LAST);

   always_ff @(posedge i_clk) begin
      if (prog_we_w) begin
         mem_q[prog_addr_w] <= pbuf_q[idx_q];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ws_q <= WS_IDLE;
         idx_q <= '0;
         wc_cnt_q <= '0;
      end else begin
         case (ws_q)
            WS_IDLE: begin
               idx_q <= '0;
               wc_cnt_q <= '0;
               if (start_wr_w) begin
                  ws_q <= WS_PROG;  // see R27
               end else if (start_sw_w) begin
                  ws_q <= WS_WAIT;
               end
            end
            WS_PROG: begin
               idx_q <= idx_q + 5'h1;
               if (idx_q == IDX_LAST) begin
                  ws_q <= WS_WAIT;
               end
            end
            WS_WAIT: begin
               wc_cnt_q <= wc_cnt_q + CNT_W'(1);  // see R28
               if (wc_done_w) begin
                  ws_q <= WS_IDLE;
               end
            end
            default: begin
               ws_q <= WS_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // system domain: latch and nonvolatile status bits
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wel_q <= 1'b0;  // see R17
      end else if (set_ok_w) begin
         wel_q <= 1'b1;  // see R22
      end else if (clr_ok_w || wc_done_w) begin
         wel_q <= 1'b0;  // see R10
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ppe_q <= PPE_RESET;
         bprot_q <= BP_RESET;
      end else if (start_sw_w) begin
         ppe_q <= frm_q.sdata[ST_PPE];  // see R23
         bprot_q <= {frm_q.sdata[ST_BPH], frm_q.sdata[ST_BPL]};
      end
   end

endmodule : seecp_top

`default_nettype wire

// *** bench/seecp_top_asserts.sv ***
// port checks for the serial eeprom command port
`timescale 1ns/1ps
`default_nettype none
module seecp_top_asserts
   import seecp_pkg::*;
#(
   parameter int WRITE_CYCLES = WC_CYCLES
) (
   // system
   input wire logic i_clk,
   input wire logic i_rst,
   // serial link
   input wire logic i_sck,
   input wire logic i_select_n,
   input wire logic i_sdi,
   input wire logic o_sdo,
   input wire logic o_sdo_oe,
   // pins
   input wire logic i_pause_n,
   input wire logic i_protect_pin_n
);
   logic [3:0] edge_q;
   logic hold_q;
   // rising serial clocks seen in this frame, saturating at one opcode
   always_ff @(posedge i_sck or posedge i_select_n) begin
      if (i_select_n) begin
         edge_q <= 4'h0;
      end else if (i_pause_n && edge_q != 4'h8) begin
         edge_q <= edge_q + 4'h1;
      end
   end
   // pause has taken hold with the serial clock low
   always_ff @(posedge i_clk) begin
      hold_q <= !i_pause_n && !i_select_n && (hold_q || !i_sck);
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_oe_sel; i_select_n |-> !o_sdo_oe; endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("output driven while deselected");
   property p_oe_pause; !i_pause_n |-> !o_sdo_oe; endproperty
   a_oe_pause: assert property (p_oe_pause) else $error("output driven while paused");
   property p_sdo_fall; (!i_select_n && !$past(i_select_n) && $changed(o_sdo)) |-> !i_sck; endproperty
   a_sdo_fall: assert property (p_sdo_fall) else $error("output moved with clock high");
   property p_oe_rise; $rose(o_sdo_oe) |-> !i_sck; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("output enabled with clock high");
   property p_rst_idle; $fell(i_rst) |-> !o_sdo_oe [*4]; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("output driven after reset");
   property p_hold_still; (hold_q && !i_pause_n) |-> $stable(o_sdo); endproperty
   a_hold_still: assert property (p_hold_still) else $error("output moved while paused");
   property p_oe_opc; o_sdo_oe |-> edge_q == 4'h8; endproperty
   a_oe_opc: assert property (p_oe_opc) else $error("output driven before opcode end");
   property p_oe_keep; $fell(o_sdo_oe) |-> (i_select_n || !i_pause_n); endproperty
   a_oe_keep: assert property (p_oe_keep) else $error("output dropped mid read");
endmodule : seecp_top_asserts
bind seecp_top seecp_top_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_sck(i_sck), .i_select_n(i_select_n), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
   .i_pause_n(i_pause_n), .i_protect_pin_n(i_protect_pin_n));
`default_nettype wire

// *** bench/seecp_host.sv ***
// host model driving the four-wire link of the eeprom command port
`timescale 1ns/1ps
`default_nettype none
module seecp_host (
   // link
   output logic o_sck,
   output logic o_select_n,
   output logic o_sdi,
   output logic o_pause_n,
   input wire logic i_sdo_line,
   // received bytes
   output logic o_rx_stb,
   output logic [7:0] o_rx
);
   initial begin
      o_sck = 1'b0;
      o_select_n = 1'b1;
      o_sdi = 1'b0;
      o_pause_n = 1'b1;
      o_rx_stb = 1'b0;
      o_rx = 8'h00;
   end
   // half ns offset keeps link edges apart from system clock edges
   task automatic sel();
      #0.5 o_select_n <= 1'b0;
   endtask : sel
   task automatic desel();
      #32 o_select_n <= 1'b1;
      o_sdi <= ~o_sdi;
      #300.5;
   endtask : desel
   task automatic bits(input logic [7:0] tx, input int n, input bit cap, input bit hold);
      logic [7:0] rx;
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         o_sdi <= tx[i];
         #32 o_sck <= 1'b1;
         rx[i] = i_sdo_line;
         #32 o_sck <= 1'b0;
         if (hold && i == 4) begin
            #8 o_pause_n <= 1'b0;
            repeat (4) #32 o_sck <= ~o_sck;
            o_sdi <= ~o_sdi;
            #8 o_pause_n <= 1'b1;
         end
      end
      if (cap) begin
         o_rx <= rx;
         o_rx_stb <= 1'b1;
         #1 o_rx_stb <= 1'b0;
      end
   endtask : bits
endmodule : seecp_host
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the serial eeprom command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
   import seecp_pkg::*;
   localparam int WCYC = 400;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic prot_n = 1'b1;
   logic sck, sel_n, sdi, pause_n, rx_stb, sdo, sdo_oe;
   logic [7:0] rx;
   wire sdo_line;
   int error_cnt = 0;
   int cmp_count = 0;
   logic [7:0] exp_q[$];
   logic [7:0] mem [ARRAY_BYTES];
   logic [1:0] bp = 2'h0;
   logic [16:0] lf = 17'h12146;
   logic [15:0] pa [4] = '{16'h0FFF, 16'h1000, 16'h17FF, 16'h1800};
   assign sdo_line = sdo_oe ? sdo : 1'bz;
   always #5 i_clk = ~i_clk;
   seecp_top #(.WRITE_CYCLES(WCYC)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_select_n(sel_n),
      .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_pause_n(pause_n), .i_protect_pin_n(prot_n));
   seecp_host host_u (.o_sck(sck), .o_select_n(sel_n), .o_sdi(sdi), .o_pause_n(pause_n),
      .i_sdo_line(sdo_line), .o_rx_stb(rx_stb), .o_rx(rx));
   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr_next
   function automatic bit prot(input logic [12:0] p);
      return bp == 2'h3 || (bp == 2'h2 && p >= PROT_HALF_BASE) || (bp == 2'h1 && p >= PROT_QTR_BASE);
   endfunction : prot
   task automatic wc();
      repeat (WCYC + 60) @(posedge i_clk);
   endtask : wc
   task automatic cmd(input logic [7:0] op, input int extra);
      host_u.sel();
      host_u.bits(op, 8, 1'b0, 1'b0);
      if (extra > 0) host_u.bits(8'hFF, extra, 1'b0, 1'b0);
      host_u.desel();
   endtask : cmd
   task automatic hdr(input logic [7:0] op, input logic [15:0] a);
      host_u.sel();
      host_u.bits(op, 8, 1'b0, 1'b0);
      host_u.bits(a[15:8], 8, 1'b0, 1'b0);
      host_u.bits(a[7:0], 8, 1'b0, 1'b0);
   endtask : hdr
   task automatic stat(input logic [7:0] e);
      exp_q.push_back(e);
      host_u.sel();
      host_u.bits(OP_STAT_RD, 8, 1'b0, 1'b0);
      host_u.bits(8'h00, 8, 1'b1, 1'b0);
      host_u.desel();
   endtask : stat
   task automatic swr(input logic [7:0] v);
      cmd(OP_SET_WEL, 0);
      host_u.sel();
      host_u.bits(OP_STAT_WR, 8, 1'b0, 1'b0);
      host_u.bits(v, 8, 1'b0, 1'b0);
      host_u.desel();
      wc();
   endtask : swr
   task automatic wr(input logic [15:0] a, input int n, input int tail, input bit en);
      logic [12:0] p;
      p = a[12:0];
      if (en) cmd(OP_SET_WEL, 0);
      hdr(OP_WRITE, a);
      for (int i = 0; i < n; i++) begin
         lf = lfsr_next(lf);
         host_u.bits(lf[7:0], 8, 1'b0, 1'b0);
         if (en && tail == 0 && !prot(p)) mem[p] = lf[7:0];
         p = {p[12:5], p[4:0] + 5'h01};
      end
      if (tail > 0) host_u.bits(8'hA5, tail, 1'b0, 1'b0);
      host_u.desel();
   endtask : wr
   task automatic rd(input logic [15:0] a, input int n, input bit busy);
      hdr(OP_READ, a);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(busy ? 8'hZZ : mem[a[12:0] + 13'(i)]);
         host_u.bits(8'h00, 8, 1'b1, i == 2);
      end
      host_u.desel();
   endtask : rd
   task automatic print_verdict();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   always @(posedge rx_stb) begin
      logic [7:0] e;
      e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
      `CHK(rx, e)
   end
   initial begin
      #800000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (6) @(posedge i_clk);
      stat(8'h00);
      wr(16'h0000, 1, 0, 0);
      wc();
      stat(8'h00);
      cmd(OP_SET_WEL, 1);
      stat(8'h00);
      cmd(OP_SET_WEL, 0);
      stat(8'h02);
      cmd(OP_CLR_WEL, 0);
      stat(8'h00);
      wr(16'h0000, 2, 3, 1);
      stat(8'h02);
      wr(16'hE000, 3, 0, 1);
      stat(8'h03);
      rd(16'h0000, 1, 1);
      wc();
      stat(8'h00);
      wr(16'hFFFE, 34, 0, 1);
      wc();
      rd(16'h1FE0, 35, 0);
      for (int b = 0; b < 4; b++) begin
         swr({4'h0, 2'(b), 2'h0});
         bp = 2'(b);
         stat({4'h0, bp, 2'h0});
         for (int k = 0; k < 4; k++) begin
            wr(pa[k], 1, 0, 1);
            wc();
            rd(pa[k], 1, 0);
         end
      end
      swr(8'h80);
      bp = 2'h0;
      @(posedge i_clk) prot_n <= 1'b0;
      swr(8'h8C);
      stat(8'h82);
      wr(16'h0100, 1, 0, 1);
      wc();
      rd(16'h0100, 1, 0);
      @(posedge i_clk) prot_n <= 1'b1;
      swr(8'h00);
      stat(8'h00);
      `CHK(exp_q.size(), 0)
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
